// ===== logic/aacc_top.sv
// Purpose: clock, port role and input routing setup
// Assumes: all clock and data pins are sampled levels, much slower than I_CLK
// Notes:   byte registers on a strobed register port
//
// Behaviour
// - per-channel analog gain mapping: 0 auto, 1 manual
// - second mic input: 00 pin zero, 01 pin one
// - first mic input: 00 pin zero, 01 pin one
// - second filter pair: converter or mic, four-channel
// - first filter pair: converter or mic samples
// - serial input reregister: none, rising, falling edge
// - master clock input: either, pin, or crystal
// - master dividers fed by master clock or PLL
// - port role: slave receives, master drives clocks
// - converter clock: master clock or PLL, auto-ignored
// - stage two clock: master clock or PLL, auto-ignored
// - stage one clock: master clock or PLL, auto-ignored
// - auto detect enable resets set, overrides stage, converter and PLL reference choices
// - stage one divider N+1, resets divide-by-one
// - stage two divider N+1, resets divide-by-two
// - converter divider N+1, resets divide-by-four
// - PLL clock output divider N+1, resets eight
// - bit clock from master divider source (master clock or PLL), N+1, four
// - word clock from bit clock, N+1, 64
// - PLL reference: master pin or bit clock
`include "aacc_cfg.svh"

module aacc_top #(
    parameter bit FOUR_CHANNEL = 1'b1
) (
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    input  wire logic [7:0] I_REG_ADDR,
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    input  wire logic [7:0] I_REG_WDATA,
    output logic      [7:0] O_REG_RDATA,
    input  wire logic       I_MCLK_PIN,
    input  wire logic       I_CRYSTAL_OSCILLATOR_CLK,
    input  wire logic       I_PLL_CLK,
    input  wire logic       I_BIT_CLOCK,
    input  wire logic       I_WORD_CLOCK,
    input  wire logic       I_GENERAL_PIN_ZERO,
    input  wire logic       I_GENERAL_PIN_ONE,
    input  wire logic       I_SERIAL_DIN,
    output logic            O_BIT_CLOCK,
    output logic            O_BIT_CLOCK_OE,
    output logic            O_WORD_CLOCK,
    output logic            O_WORD_CLOCK_OE,
    output logic            O_CONV_CLK,
    output logic            O_STAGE1_CLK,
    output logic            O_STAGE2_CLK,
    output logic            O_PLL_CLK_OUT,
    output logic            O_PLL_REF,
    output logic            O_FIRST_MIC_DATA,
    output logic            O_SECOND_MIC_DATA,
    output logic            O_FIRST_FILTER_MIC,
    output logic            O_SECOND_FILTER_MIC,
    output logic            O_SERIAL_DATA,
    output logic      [2:0] O_ANALOG_GAIN_MANUAL
);

    localparam int PN = `AACC_PIN_COUNT;

    typedef struct packed {
        aacc_pkg::aacc_regs_t regs;
        logic [PN-1:0]        sync1;
        logic [PN-1:0]        sync2;
        logic [PN-1:0]        prev;
        logic                 mclk_prev;
        logic                 bck_prev;
        logic                 din_hold;
        logic [7:0]           rdata;
        logic                 bck_out;
        logic                 bck_oe;
        logic                 wck_out;
        logic                 wck_oe;
        logic                 conv_clk;
        logic                 s1_clk;
        logic                 s2_clk;
        logic                 pll_out;
        logic                 pll_ref;
        logic                 first_mic_interface;
        logic                 second_mic_interface;
        logic                 f1_mic;
        logic                 f2_mic;
        logic                 ser_data;
        logic [2:0]           gain;
    } aacc_top_st_t;

    aacc_top_st_t st;
    aacc_top_st_t next_st;

    // read-back of one register; unmapped offsets answer zero
    function automatic logic [7:0] reg_read(input aacc_pkg::aacc_regs_t r, input logic [7:0] a);
        logic [7:0] v;
        case (a)
            `AACC_OFS_GAIN_MAP: v = r.gain_map;
            `AACC_OFS_MIC_CFG:  v = r.mic_cfg;
            `AACC_OFS_RESAMPLE: v = r.resample;
            `AACC_OFS_CLK_SRC:  v = r.clk_src;
            `AACC_OFS_DIV_S1:   v = r.div_s1;
            `AACC_OFS_DIV_S2:   v = r.div_s2;
            `AACC_OFS_DIV_CONV: v = r.div_conv;
            `AACC_OFS_DIV_PLL:  v = r.div_pll;
            `AACC_OFS_DIV_BIT:  v = r.div_bit;
            `AACC_OFS_DIV_WORD: v = r.div_word;
            `AACC_OFS_PLL_CFG:  v = r.pll_cfg;
            default:            v = `AACC_RDATA_NONE;
        endcase
        return v;
    endfunction

    // mic data routing; invalid codes give a quiet zero input
    function automatic logic mic_route(input logic [1:0] sel, input logic gp0, input logic gp1);
        return (sel == `AACC_SEL_PIN0) ? gp0 : (sel == `AACC_SEL_PIN1) ? gp1 : 1'b0;
    endfunction

    // shared source terms
    logic       auto_on;
    logic       mclk_lvl;
    logic       mclk_tick;
    logic       pll_lvl;
    logic       pll_tick;
    logic       mdiv_lvl;
    logic       mdiv_tick;
    logic       conv_lvl;
    logic       conv_tick;
    logic       s1_lvl;
    logic       s1_tick;
    logic       s2_lvl;
    logic       s2_tick;
    logic [6:0] div_s1;
    logic [6:0] div_s2;
    logic [6:0] div_conv;
    logic       conv_clk;
    logic       s1_clk;
    logic       s2_clk;
    logic       pll_clk;
    logic       bit_clk;
    logic       bit_tick;
    logic       word_clk;
    logic       is_master;
    logic       bck_lvl;

    // pin and crystal are never both fitted, so "either" ORs them
    always_comb begin
        auto_on = st.regs.clk_src[`AACC_AUTO_BIT];
        case (st.regs.clk_src[`AACC_MCLK_SEL_RNG])
            `AACC_MCLK_PIN:  mclk_lvl = st.sync2[`AACC_PIN_MCLK];
            `AACC_MCLK_CRYSTAL_OSCILLATOR: mclk_lvl = st.sync2[`AACC_PIN_CRYSTAL_OSCILLATOR];
            default:         mclk_lvl = st.sync2[`AACC_PIN_MCLK] | st.sync2[`AACC_PIN_CRYSTAL_OSCILLATOR];
        endcase
        mclk_tick = mclk_lvl & ~st.mclk_prev;
        pll_lvl   = st.sync2[`AACC_PIN_PLL];
        pll_tick  = pll_lvl & ~st.prev[`AACC_PIN_PLL];
        // master dividers follow their source bit even under auto detection
        mdiv_lvl  = st.regs.clk_src[`AACC_MDIV_SRC_BIT] ? pll_lvl : mclk_lvl;
        mdiv_tick = st.regs.clk_src[`AACC_MDIV_SRC_BIT] ? pll_tick : mclk_tick;
        // auto detection forces master clock and reset dividers
        conv_lvl  = (!auto_on && st.regs.clk_src[`AACC_CONV_SRC_BIT]) ? pll_lvl : mclk_lvl;
        conv_tick = (!auto_on && st.regs.clk_src[`AACC_CONV_SRC_BIT]) ? pll_tick : mclk_tick;
        s2_lvl    = (!auto_on && st.regs.clk_src[`AACC_S2_SRC_BIT]) ? pll_lvl : mclk_lvl;
        s2_tick   = (!auto_on && st.regs.clk_src[`AACC_S2_SRC_BIT]) ? pll_tick : mclk_tick;
        s1_lvl    = (!auto_on && st.regs.clk_src[`AACC_S1_SRC_BIT]) ? pll_lvl : mclk_lvl;
        s1_tick   = (!auto_on && st.regs.clk_src[`AACC_S1_SRC_BIT]) ? pll_tick : mclk_tick;
        div_s1    = auto_on ? 7'(`AACC_RST_DIV_S1) : st.regs.div_s1[`AACC_DIV7_RNG];
        div_s2    = auto_on ? 7'(`AACC_RST_DIV_S2) : st.regs.div_s2[`AACC_DIV7_RNG];
        div_conv  = auto_on ? 7'(`AACC_RST_DIV_CONV) : st.regs.div_conv[`AACC_DIV7_RNG];
        is_master = st.regs.clk_src[`AACC_ROLE_BIT];
    end

    // stage and converter clocks
    aacc_divider #(.WIDTH(7), .RESET_DIV(7'(`AACC_RST_DIV_S1))) u_div_s1 (
        .i_clk  (I_CLK),
        .i_rst  (I_SYS_RST),
        .i_src  (s1_lvl),
        .i_tick (s1_tick),
        .i_div  (div_s1),
        .o_clk  (s1_clk),
        .o_tick ()
    );
    aacc_divider #(.WIDTH(7), .RESET_DIV(7'(`AACC_RST_DIV_S2))) u_div_s2 (
        .i_clk  (I_CLK),
        .i_rst  (I_SYS_RST),
        .i_src  (s2_lvl),
        .i_tick (s2_tick),
        .i_div  (div_s2),
        .o_clk  (s2_clk),
        .o_tick ()
    );
    aacc_divider #(.WIDTH(7), .RESET_DIV(7'(`AACC_RST_DIV_CONV))) u_div_conv (
        .i_clk  (I_CLK),
        .i_rst  (I_SYS_RST),
        .i_src  (conv_lvl),
        .i_tick (conv_tick),
        .i_div  (div_conv),
        .o_clk  (conv_clk),
        .o_tick ()
    );

    // PLL output divider needs software to pick the PLL source
    aacc_divider #(.WIDTH(7), .RESET_DIV(7'(`AACC_RST_DIV_PLL))) u_div_pll (
        .i_clk  (I_CLK),
        .i_rst  (I_SYS_RST),
        .i_src  (mdiv_lvl),
        .i_tick (mdiv_tick),
        .i_div  (st.regs.div_pll[`AACC_DIV7_RNG]),
        .o_clk  (pll_clk),
        .o_tick ()
    );

    // bit clock from master divider source, word clock from bit clock
    aacc_divider #(.WIDTH(7), .RESET_DIV(7'(`AACC_RST_DIV_BIT))) u_div_bit (
        .i_clk  (I_CLK),
        .i_rst  (I_SYS_RST),
        .i_src  (mdiv_lvl),
        .i_tick (mdiv_tick),
        .i_div  (st.regs.div_bit[`AACC_DIV7_RNG]),
        .o_clk  (bit_clk),
        .o_tick (bit_tick)
    );

    aacc_divider #(.WIDTH(8), .RESET_DIV(`AACC_RST_DIV_WORD)) u_div_word (
        .i_clk  (I_CLK),
        .i_rst  (I_SYS_RST),
        .i_src  (bit_clk),
        .i_tick (bit_tick),
        .i_div  (st.regs.div_word),
        .o_clk  (word_clk),
        .o_tick ()
    );

    // register port, synchronisers, routing and registered outputs
    always_comb begin
        next_st       = st;
        next_st.sync1 = {I_SERIAL_DIN, I_GENERAL_PIN_ONE, I_GENERAL_PIN_ZERO, I_WORD_CLOCK,
                         I_BIT_CLOCK, I_PLL_CLK, I_CRYSTAL_OSCILLATOR_CLK, I_MCLK_PIN};
        next_st.sync2     = st.sync1;
        next_st.prev      = st.sync2;
        next_st.mclk_prev = mclk_lvl;
        // reserved bits masked off, so they read back zero
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                `AACC_OFS_GAIN_MAP: next_st.regs.gain_map = I_REG_WDATA & `AACC_MSK_GAIN_MAP;
                `AACC_OFS_MIC_CFG:  next_st.regs.mic_cfg  = I_REG_WDATA & `AACC_MSK_MIC_CFG;
                `AACC_OFS_RESAMPLE: next_st.regs.resample = I_REG_WDATA & `AACC_MSK_RESAMPLE;
                `AACC_OFS_CLK_SRC:  next_st.regs.clk_src  = I_REG_WDATA & `AACC_MSK_CLK_SRC;
                `AACC_OFS_DIV_S1:   next_st.regs.div_s1   = I_REG_WDATA & `AACC_MSK_DIV7;
                `AACC_OFS_DIV_S2:   next_st.regs.div_s2   = I_REG_WDATA & `AACC_MSK_DIV7;
                `AACC_OFS_DIV_CONV: next_st.regs.div_conv = I_REG_WDATA & `AACC_MSK_DIV7;
                `AACC_OFS_DIV_PLL:  next_st.regs.div_pll  = I_REG_WDATA & `AACC_MSK_DIV7;
                `AACC_OFS_DIV_BIT:  next_st.regs.div_bit  = I_REG_WDATA & `AACC_MSK_DIV7;
                `AACC_OFS_DIV_WORD: next_st.regs.div_word = I_REG_WDATA & `AACC_MSK_DIV8;
                `AACC_OFS_PLL_CFG:  next_st.regs.pll_cfg  = I_REG_WDATA & `AACC_MSK_PLL_CFG;
                default:            next_st.regs = st.regs;
            endcase
        end
        if (I_REG_RD) begin
            next_st.rdata = reg_read(st.regs, I_REG_ADDR);
        end
        // port role: drive the divided clocks only as master
        next_st.bck_oe  = is_master;
        next_st.wck_oe  = is_master;
        next_st.bck_out = is_master & bit_clk;
        next_st.wck_out = is_master & word_clk;
        bck_lvl         = is_master ? bit_clk : st.sync2[`AACC_PIN_BCK];
        next_st.bck_prev = bck_lvl;
        // serial data re-registered on the chosen bit clock edge
        case (st.regs.resample[`AACC_RESAMP_RNG])
            `AACC_RESAMP_RISE: begin
                if (bck_lvl && !st.bck_prev) begin
                    next_st.din_hold = st.sync2[`AACC_PIN_DIN];
                end
                next_st.ser_data = st.din_hold;
            end
            `AACC_RESAMP_FALL: begin
                if (!bck_lvl && st.bck_prev) begin
                    next_st.din_hold = st.sync2[`AACC_PIN_DIN];
                end
                next_st.ser_data = st.din_hold;
            end
            default: begin
                next_st.din_hold = st.sync2[`AACC_PIN_DIN];
                next_st.ser_data = st.sync2[`AACC_PIN_DIN];
            end
        endcase
        // auto detection sends the PLL reference back to the pin
        next_st.pll_ref = (!auto_on && st.regs.pll_cfg[`AACC_PLL_REF_BIT]) ?
                          bck_lvl : st.sync2[`AACC_PIN_MCLK];
        next_st.conv_clk = conv_clk;
        next_st.s1_clk   = s1_clk;
        next_st.s2_clk   = s2_clk;
        next_st.pll_out  = pll_clk;
        // mic routing, filter pairs; second pair on four-channel parts only
        next_st.first_mic_interface = mic_route(st.regs.mic_cfg[`AACC_FIRST_MIC_INTERFACE_SEL_RNG],
                                 st.sync2[`AACC_PIN_GP0], st.sync2[`AACC_PIN_GP1]);
        next_st.second_mic_interface = FOUR_CHANNEL & mic_route(st.regs.mic_cfg[`AACC_SECOND_MIC_INTERFACE_SEL_RNG],
                                 st.sync2[`AACC_PIN_GP0], st.sync2[`AACC_PIN_GP1]);
        next_st.f1_mic = st.regs.mic_cfg[`AACC_F1_SRC_BIT];
        next_st.f2_mic = FOUR_CHANNEL & st.regs.mic_cfg[`AACC_F2_SRC_BIT];
        next_st.gain   = st.regs.gain_map[`AACC_GAIN_MAP_RNG];
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st      <= '0;
            st.regs <= {`AACC_RST_GAIN_MAP, `AACC_RST_MIC_CFG, `AACC_RST_RESAMPLE, `AACC_RST_CLK_SRC,
                        `AACC_RST_DIV_S1, `AACC_RST_DIV_S2, `AACC_RST_DIV_CONV, `AACC_RST_DIV_PLL,
                        `AACC_RST_DIV_BIT, `AACC_RST_DIV_WORD, `AACC_RST_PLL_CFG};
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign O_REG_RDATA          = st.rdata;
    assign O_BIT_CLOCK          = st.bck_out;
    assign O_BIT_CLOCK_OE       = st.bck_oe;
    assign O_WORD_CLOCK         = st.wck_out;
    assign O_WORD_CLOCK_OE      = st.wck_oe;
    assign O_CONV_CLK           = st.conv_clk;
    assign O_STAGE1_CLK         = st.s1_clk;
    assign O_STAGE2_CLK         = st.s2_clk;
    assign O_PLL_CLK_OUT        = st.pll_out;
    assign O_PLL_REF            = st.pll_ref;
    assign O_FIRST_MIC_DATA     = st.first_mic_interface;
    assign O_SECOND_MIC_DATA    = st.second_mic_interface;
    assign O_FIRST_FILTER_MIC   = st.f1_mic;
    assign O_SECOND_FILTER_MIC  = st.f2_mic;
    assign O_SERIAL_DATA        = st.ser_data;
    assign O_ANALOG_GAIN_MANUAL = st.gain;

endmodule

// ===== common/aacc_cfg.svh
// Purpose: offsets, reset values, fields and codes of the clock setup block
// Assumes: 8-bit registers at their printed byte offsets
// Notes:   included by its bare name; definitions only
`ifndef AACC_CFG_SVH
`define AACC_CFG_SVH

// register offsets
`define AACC_OFS_GAIN_MAP   8'h19
`define AACC_OFS_MIC_CFG    8'h1a
`define AACC_OFS_RESAMPLE   8'h1b
`define AACC_OFS_CLK_SRC    8'h20
`define AACC_OFS_DIV_S1     8'h21
`define AACC_OFS_DIV_S2     8'h22
`define AACC_OFS_DIV_CONV   8'h23
`define AACC_OFS_DIV_PLL    8'h25
`define AACC_OFS_DIV_BIT    8'h26
`define AACC_OFS_DIV_WORD   8'h27
`define AACC_OFS_PLL_CFG    8'h28

// reset values
`define AACC_RST_GAIN_MAP   8'h00
`define AACC_RST_MIC_CFG    8'h00
`define AACC_RST_RESAMPLE   8'h00
`define AACC_RST_CLK_SRC    8'h01
`define AACC_RST_DIV_S1     8'h00
`define AACC_RST_DIV_S2     8'h01
`define AACC_RST_DIV_CONV   8'h03
`define AACC_RST_DIV_PLL    8'h07
`define AACC_RST_DIV_BIT    8'h03
`define AACC_RST_DIV_WORD   8'h3f
`define AACC_RST_PLL_CFG    8'h00
`define AACC_RDATA_NONE     8'h00

// writable bits; reserved bits are not stored
`define AACC_MSK_GAIN_MAP   8'h07
`define AACC_MSK_MIC_CFG    8'hf3
`define AACC_MSK_RESAMPLE   8'h03
`define AACC_MSK_CLK_SRC    8'hff
`define AACC_MSK_DIV7       8'h7f
`define AACC_MSK_DIV8       8'hff
`define AACC_MSK_PLL_CFG    8'h02

// field positions
`define AACC_GAIN_MAP_RNG   2:0
`define AACC_SECOND_MIC_INTERFACE_SEL_RNG   7:6
`define AACC_FIRST_MIC_INTERFACE_SEL_RNG   5:4
`define AACC_F2_SRC_BIT     1
`define AACC_F1_SRC_BIT     0
`define AACC_RESAMP_RNG     1:0
`define AACC_MCLK_SEL_RNG   7:6
`define AACC_MDIV_SRC_BIT   5
`define AACC_ROLE_BIT       4
`define AACC_CONV_SRC_BIT   3
`define AACC_S2_SRC_BIT     2
`define AACC_S1_SRC_BIT     1
`define AACC_AUTO_BIT       0
`define AACC_DIV7_RNG       6:0
`define AACC_PLL_REF_BIT    1

// field codes
`define AACC_SEL_PIN0       2'h0
`define AACC_SEL_PIN1       2'h1
`define AACC_RESAMP_RISE    2'h1
`define AACC_RESAMP_FALL    2'h2
`define AACC_MCLK_PIN       2'h1
`define AACC_MCLK_CRYSTAL_OSCILLATOR      2'h2

// positions in the synchroniser vector
`define AACC_PIN_COUNT      8
`define AACC_PIN_MCLK       0
`define AACC_PIN_CRYSTAL_OSCILLATOR       1
`define AACC_PIN_PLL        2
`define AACC_PIN_BCK        3
`define AACC_PIN_WCK        4
`define AACC_PIN_GP0        5
`define AACC_PIN_GP1        6
`define AACC_PIN_DIN        7

`endif

// ===== common/aacc_pkg.sv
// Purpose: types shared by the clock configuration block
// Assumes: nothing beyond the cfg header
// Notes:   nothing is imported; users write aacc_pkg::name
package aacc_pkg;

    // software-visible register file, one byte per register
    typedef struct packed {
        logic [7:0] gain_map;
        logic [7:0] mic_cfg;
        logic [7:0] resample;
        logic [7:0] clk_src;
        logic [7:0] div_s1;
        logic [7:0] div_s2;
        logic [7:0] div_conv;
        logic [7:0] div_pll;
        logic [7:0] div_bit;
        logic [7:0] div_word;
        logic [7:0] pll_cfg;
    } aacc_regs_t;

endpackage

// ===== logic/aacc_divider.sv
// Purpose: integer clock divider driven by source edge ticks
// Assumes: i_tick marks each rising edge of i_src
// Notes:   period is div+1 source periods; new div taken at reload
module aacc_divider #(
    parameter int                WIDTH     = 7,
    parameter logic [WIDTH-1:0]  RESET_DIV = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_src,
    input  wire logic             i_tick,
    input  wire logic [WIDTH-1:0] i_div,
    output logic                  o_clk,
    output logic                  o_tick
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic [WIDTH-1:0] cur;
        logic             clk;
        logic             tick;
    } aacc_div_st_t;

    aacc_div_st_t st;
    aacc_div_st_t next_st;
    logic [WIDTH:0] half;

    // count ticks, reload the programmed value at period end
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (i_tick) begin
            if (st.cnt >= st.cur) begin
                next_st.cnt  = '0;
                next_st.cur  = i_div;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
        // high for the first half of the period; divide-by-one follows the source
        half = ({1'b0, st.cur} + 1'b1) >> 1;
        if (st.cur == '0) begin
            next_st.clk = i_src;
        end else begin
            next_st.clk = ({1'b0, next_st.cnt} < half);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '{cnt: '0, cur: RESET_DIV, clk: 1'b0, tick: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_clk  = st.clk;
    assign o_tick = st.tick;

endmodule

// ===== verif/aacc_asserts.sv
// Purpose: port assertions for aacc_top
// Assumes: register shadows follow the strobed writes
// Notes:   attached by bind at the foot of this file
`include "aacc_cfg.svh"
module aacc_chk (
    input wire logic       I_CLK,
    input wire logic       I_SYS_RST,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic       I_REG_WR,
    input wire logic       I_REG_RD,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic       I_GENERAL_PIN_ZERO,
    input wire logic       I_GENERAL_PIN_ONE,
    input wire logic       I_SERIAL_DIN,
    input wire logic       O_BIT_CLOCK,
    input wire logic       O_BIT_CLOCK_OE,
    input wire logic       O_FIRST_MIC_DATA,
    input wire logic       O_FIRST_FILTER_MIC,
    input wire logic       O_SECOND_FILTER_MIC,
    input wire logic       O_SERIAL_DATA,
    input wire logic [2:0] O_ANALOG_GAIN_MANUAL
);
    timeunit 1ns / 1ns;
    logic [13:0] sh;
    logic [13:0] sh_d;
    logic [2:0]  up;
    // shadow of written fields; delayed copy matches registered outputs
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sh <= '0;
            sh_d <= '0;
            up <= '0;
        end else begin
            sh_d <= sh;
            up <= up + {2'h0, up != 3'h7};
            if (I_REG_WR && I_REG_ADDR == `AACC_OFS_MIC_CFG) sh[7:0] <= I_REG_WDATA;
            if (I_REG_WR && I_REG_ADDR == `AACC_OFS_RESAMPLE) sh[9:8] <= I_REG_WDATA[1:0];
            if (I_REG_WR && I_REG_ADDR == `AACC_OFS_GAIN_MAP) sh[12:10] <= I_REG_WDATA[2:0];
            if (I_REG_WR && I_REG_ADDR == `AACC_OFS_CLK_SRC) sh[13] <= I_REG_WDATA[4];
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    sequence s_gap_rd;
        I_REG_RD && I_REG_ADDR == 8'h24;
    endsequence
    // pin paths need three edges of history
    sequence s_settled;
        up == 3'h7;
    endsequence
    property p_gap_rd; s_gap_rd |=> O_REG_RDATA == 8'h00; endproperty
    property p_hold; !I_REG_RD |=> $stable(O_REG_RDATA); endproperty
    property p_gain; O_ANALOG_GAIN_MANUAL == sh_d[12:10]; endproperty
    property p_pair1; O_FIRST_FILTER_MIC == sh_d[0]; endproperty
    property p_pair2; O_SECOND_FILTER_MIC == sh_d[1]; endproperty
    property p_first_mic_interface;
        s_settled |-> O_FIRST_MIC_DATA == (sh_d[5:4] == 2'h0 ? $past(I_GENERAL_PIN_ZERO, 3) :
            sh_d[5:4] == 2'h1 ? $past(I_GENERAL_PIN_ONE, 3) : 1'b0);
    endproperty
    property p_ser; s_settled ##0 sh_d[9:8] == 2'h0 |-> O_SERIAL_DATA == $past(I_SERIAL_DIN, 3); endproperty
    property p_role; O_BIT_CLOCK_OE == sh_d[13]; endproperty
    property p_slave; !O_BIT_CLOCK_OE |-> !O_BIT_CLOCK; endproperty
    a_gap_rd: assert property (p_gap_rd) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    a_gain: assert property (p_gain) else $error("gain mapping wrong");
    a_pair1: assert property (p_pair1) else $error("first pair source wrong");
    a_pair2: assert property (p_pair2) else $error("second pair source wrong");
    a_first_mic_interface: assert property (p_first_mic_interface) else $error("first mic routing wrong");
    a_ser: assert property (p_ser) else $error("serial pass-through wrong");
    a_role: assert property (p_role) else $error("port role wrong");
    a_slave: assert property (p_slave) else $error("bit clock driven as slave");
endmodule
bind aacc_top aacc_chk i_aacc_chk (.*);

// ===== verif/aacc_host.sv
// Purpose: clock and data sources beyond the block
// Assumes: host drives bit and word clocks only while the block is slave
// Notes:   no crystal fitted, so that pin stays low
module aacc_host (
    input  wire logic i_clk,
    input  wire logic i_bck_oe,
    input  wire logic i_bck,
    input  wire logic i_wck_oe,
    input  wire logic i_wck,
    output logic      o_mclk,
    output logic      o_crystal_oscillator,
    output logic      o_pll,
    output logic      o_bck,
    output logic      o_wck,
    output logic      o_gp0,
    output logic      o_gp1,
    output logic      o_din
);
    timeunit 1ns / 1ns;
    logic [9:0] cnt = '0;
    // free-running sources: master clock 8 cycles, pll 4 cycles
    always @(posedge i_clk) cnt <= #2 cnt + 10'h1;
    assign o_mclk = cnt[2];
    assign o_crystal_oscillator = 1'b0;
    assign o_pll = cnt[1];
    // shared wires: the block's driver wins while it is master
    assign o_bck = i_bck_oe ? i_bck : cnt[4];
    assign o_wck = i_wck_oe ? i_wck : cnt[9];
    assign o_gp0 = cnt[3] ^ cnt[6];
    assign o_gp1 = cnt[5];
    assign o_din = cnt[4] ^ cnt[7];
endmodule

// ===== verif/aacc_top_tb.sv
// Purpose: self-checking bench of aacc_top
// Assumes: host master clock 8 cycles, pll 4
// Notes:   periods measured between third and fourth rising edge
module aacc_top_tb;
    timeunit 1ns / 1ns;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] addr = '0;
    logic [7:0] wdata = '0;
    logic [7:0] rdata;
    logic [2:0] gain;
    logic [5:0] clks;
    logic [7:0] pin;
    logic [3:0] oe;
    logic [1:0] pair;
    int         n_mismatch = 0;
    int         n_compared = 0;
    initial forever #10 clk = ~clk;
    aacc_top i_aacc_top (.I_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_MCLK_PIN(pin[0]), .I_CRYSTAL_OSCILLATOR_CLK(pin[1]), .I_PLL_CLK(pin[2]),
        .I_BIT_CLOCK(pin[3]), .I_WORD_CLOCK(pin[4]), .I_GENERAL_PIN_ZERO(pin[5]), .I_GENERAL_PIN_ONE(pin[6]),
        .I_SERIAL_DIN(pin[7]), .O_BIT_CLOCK(clks[0]), .O_BIT_CLOCK_OE(oe[0]), .O_WORD_CLOCK(clks[5]),
        .O_WORD_CLOCK_OE(oe[1]), .O_CONV_CLK(clks[1]), .O_STAGE1_CLK(clks[2]), .O_STAGE2_CLK(clks[3]),
        .O_PLL_CLK_OUT(clks[4]), .O_PLL_REF(), .O_FIRST_MIC_DATA(oe[2]), .O_SECOND_MIC_DATA(oe[3]),
        .O_FIRST_FILTER_MIC(pair[0]), .O_SECOND_FILTER_MIC(pair[1]), .O_SERIAL_DATA(), .O_ANALOG_GAIN_MANUAL(gain));
    aacc_host i_aacc_host (.i_clk(clk), .i_bck_oe(oe[0]), .i_bck(clks[0]), .i_wck_oe(oe[1]), .i_wck(clks[5]),
        .o_mclk(pin[0]), .o_crystal_oscillator(pin[1]), .o_pll(pin[2]), .o_bck(pin[3]), .o_wck(pin[4]), .o_gp0(pin[5]),
        .o_gp1(pin[6]), .o_din(pin[7]));
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobes fall one cycle later, so back-to-back calls never collide
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 {addr, wdata, wr} = {a, d, 1'b1};
        @(posedge clk);
        #2 wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #2 {addr, rd} = {a, 1'b1};
        @(posedge clk);
        #2 rd = 1'b0;
        @(posedge clk);
        #2 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // period of clock k in cycles; a stuck clock ends the run
    task automatic per(input int k, input logic [15:0] exp);
        logic p;
        int   c;
        int   r;
        int   t;
        p = 1'b1;
        r = 0;
        t = 0;
        for (c = 0; c < 9000 && r < 4; c++) begin
            @(posedge clk);
            #2 if (clks[k] && !p) r++;
            if (r == 3 && t == 0) t = c;
            p = clks[k];
        end
        if (r < 4) begin
            n_mismatch++;
            $display("ERROR %0t: clock %0d stuck", $time, k);
            summarize();
        end else chk(16'(c - 1 - t), exp);
    endtask
    task automatic t_reset();
        logic [7:0] ra [9] = '{8'h1a, 8'h1b, 8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h24};
        logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h03, 8'h07, 8'h03, 8'h00};
        for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
        per(1, 16'h0020);
        per(2, 16'h0008);
        per(3, 16'h0010);
        $display("reset values done");
    endtask
    task automatic t_route();
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h1a, {2'(i), 2'(i), 2'h0, i[0], ~i[0]});
            wr_reg(8'h1b, 8'(i));
            wr_reg(8'h19, 8'(5 - i));
            repeat (40) @(posedge clk);
            #2 chk({14'h0000, pair}, {14'h0000, i[0], ~i[0]});
            chk({13'h0000, gain}, 16'(5 - i));
            rd_chk(8'h1a, {2'(i), 2'(i), 2'h0, i[0], ~i[0]});
        end
        $display("routing done");
    endtask
    task automatic t_clocks();
        wr_reg(8'h20, 8'h00);
        wr_reg(8'h21, 8'h02);
        wr_reg(8'h22, 8'h04);
        wr_reg(8'h23, 8'h00);
        per(2, 16'h0018);
        per(3, 16'h0028);
        per(1, 16'h0008);
        wr_reg(8'h20, 8'h0e);
        per(1, 16'h0004);
        per(2, 16'h000c);
        per(3, 16'h0014);
        wr_reg(8'h20, 8'h0f);
        per(1, 16'h0020);
        $display("clock sources done");
    endtask
    task automatic t_master();
        wr_reg(8'h20, 8'h10);
        wr_reg(8'h27, 8'h01);
        per(0, 16'h0020);
        per(5, 16'h0040);
        wr_reg(8'h20, 8'h30);
        per(4, 16'h0020);
        per(0, 16'h0010);
        $display("master mode done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #2 rst = 1'b0;
        t_reset();
        t_route();
        t_clocks();
        t_master();
        summarize();
    end
endmodule
